/* inc/chain_timer_defs.svh */
`ifndef CHAIN_TIMER_DEFS_SVH
`define CHAIN_TIMER_DEFS_SVH

// register offsets
`define OFS_MODE_CTRL    4'h0
`define OFS_WAVE_CTRL    4'h1
`define OFS_FIRST_CTRL   4'h2
`define OFS_SECOND_CTRL  4'h3
`define OFS_FIRST_RELOAD 4'h4
`define OFS_SECOND_RELOAD 4'h5
`define OFS_COUNT_LOW    4'h6
`define OFS_COUNT_HIGH   4'h7
`define OFS_FLAGS        4'h8

// mode control bits
`define BIT_CHAIN_MODE   3
`define BIT_COUNTER_MODE 2
`define BIT_FILTER_EN    1
`define BIT_EDGE_SEL     0
// wave control bits
`define BIT_CHANNEL_SEL  3
`define BIT_WAVE_EN      2
`define BIT_SRC_SECOND   1
`define BIT_SRC_FIRST    0
// per timer control bits
`define BIT_RATIO_MSB    3
`define BIT_RATIO_LSB    2
`define BIT_RELOAD_STB   1
`define BIT_RUN          0
// flag bits
`define BIT_FLAG_SECOND  1
`define BIT_FLAG_FIRST   0

// prescaler terminal masks
`define MASK_DIV1        8'h00
`define MASK_DIV4        8'h03
`define MASK_DIV32       8'h1F
`define MASK_DIV256      8'hFF

`define BYTE_ZERO        8'h00
`define NIBBLE_ZERO      4'h0
`define FILTER_EDGES     2'h2

`endif

/* inc/chain_timer_pkg.sv */
package chain_timer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] nibble_t;
    typedef enum logic [1:0] {
        RATIO_DIV1,
        RATIO_DIV4,
        RATIO_DIV32,
        RATIO_DIV256
    } ratio_t;
    typedef enum logic [1:0] {
        FILT_IDLE,
        FILT_WAIT
    } filter_state_t;
endpackage

/* design/event_conditioner.sv */
`timescale 1ns/10ps
`include "chain_timer_defs.svh"
module event_conditioner
    import chain_timer_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic event_in,
    input  wire logic filter_clk_in,
    input  wire logic filter_en_in,
    input  wire logic edge_sel_in,
    output logic      event_tick_out
);
    logic          sync_a;
    logic          sync_b;
    logic          level;
    logic          filt_clk_d;
    logic [1:0]    edges;
    filter_state_t state;
    logic          next_level;
    logic [1:0]    next_edges;
    filter_state_t next_state;
    logic          next_tick;
    logic          fall_2k;

    assign fall_2k = filt_clk_d & ~filter_clk_in;

    always_comb begin
        next_level = level;
        next_edges = edges;
        next_state = state;
        next_tick  = 1'b0;
        if (!filter_en_in) begin
            next_level = sync_b;
            next_state = FILT_IDLE;
            next_edges = 2'h0;
        end else begin
            case (state)
                FILT_IDLE: begin
                    next_edges = 2'h0;
                    if (sync_b != level) begin
                        next_state = FILT_WAIT;
                    end
                end
                FILT_WAIT: begin
                    // a level that falls back early is noise
                    if (sync_b == level) begin
                        next_state = FILT_IDLE;
                    end else if (fall_2k) begin
                        next_edges = edges + 2'h1;
                        if (edges + 2'h1 == `FILTER_EDGES) begin
                            next_level = sync_b;
                            next_state = FILT_IDLE;
                        end
                    end
                end
                default: next_state = FILT_IDLE;
            endcase
        end
        if (next_level != level) begin
            next_tick = (next_level == edge_sel_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a         <= 1'b1;
            sync_b         <= 1'b1;
            level          <= 1'b1;
            filt_clk_d     <= 1'b0;
            edges          <= 2'h0;
            state          <= FILT_IDLE;
            event_tick_out <= 1'b0;
        end else begin
            sync_a         <= event_in;
            sync_b         <= sync_a;
            level          <= next_level;
            filt_clk_d     <= filter_clk_in;
            edges          <= next_edges;
            state          <= next_state;
            event_tick_out <= next_tick;
        end
    end
endmodule

/* design/chain_timer.sv */
`timescale 1ns/10ps
`include "chain_timer_defs.svh"
module chain_timer
    import chain_timer_pkg::*;
(
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic [3:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    input  wire logic       LOW_OSC_IN,
    input  wire logic       HIGH_OSC_IN,
    input  wire logic       FILTER_CLK_IN,
    input  wire logic       EVENT_PIN_IN,
    output logic            WAVE_PIN_OUT,
    output logic            SERIAL_CLK_OUT,
    output logic            SECOND_FLAG_OUT
);
    nibble_t mode_ctrl;
    nibble_t wave_ctrl;
    nibble_t first_ctrl;
    nibble_t second_ctrl;
    byte_t   first_reload;
    byte_t   second_reload;
    byte_t   first_count;
    byte_t   second_count;
    byte_t   high_hold;
    logic [1:0] flags;
    logic    wave;
    logic    serial_clk;
    byte_t   first_pre;
    byte_t   second_pre;
    logic    low_d;
    logic    high_d;
    byte_t   rdata;

    nibble_t next_mode_ctrl;
    nibble_t next_wave_ctrl;
    nibble_t next_first_ctrl;
    nibble_t next_second_ctrl;
    byte_t   next_first_reload;
    byte_t   next_second_reload;
    byte_t   next_first_count;
    byte_t   next_second_count;
    byte_t   next_high_hold;
    logic [1:0] next_flags;
    logic    next_wave;
    logic    next_serial_clk;
    byte_t   next_first_pre;
    byte_t   next_second_pre;
    byte_t   next_rdata;

    logic    chain;
    logic    event_mode;
    logic    event_tick;
    logic    first_run;
    logic    second_run;
    logic    first_src_tick;
    logic    second_src_tick;
    logic    first_pre_tick;
    logic    second_pre_tick;
    logic    first_tick;
    logic    second_tick;
    logic    first_uf;
    logic    second_uf;
    logic    wave_uf;
    logic    first_stb;
    logic    second_stb;
    byte_t   first_mask;
    byte_t   second_mask;

    event_conditioner u_event (
        .clk_in         (SYS_CLK_IN),
        .rst_n_in       (RST_N_IN),
        .event_in       (EVENT_PIN_IN),
        .filter_clk_in  (FILTER_CLK_IN),
        .filter_en_in   (mode_ctrl[`BIT_FILTER_EN]),
        .edge_sel_in    (mode_ctrl[`BIT_EDGE_SEL]),
        .event_tick_out (event_tick)
    );

    function automatic byte_t ratio_mask(input ratio_t r);
        byte_t m;
        case (r)
            RATIO_DIV4:   m = `MASK_DIV4;
            RATIO_DIV32:  m = `MASK_DIV32;
            RATIO_DIV256: m = `MASK_DIV256;
            default:      m = `MASK_DIV1;
        endcase
        return m;
    endfunction

    assign chain      = mode_ctrl[`BIT_CHAIN_MODE];
    assign event_mode = mode_ctrl[`BIT_COUNTER_MODE];
    assign first_run  = first_ctrl[`BIT_RUN];
    assign second_run = chain ? first_run : second_ctrl[`BIT_RUN];

    assign first_src_tick  = wave_ctrl[`BIT_SRC_FIRST]
                           ? (HIGH_OSC_IN & ~high_d) : (LOW_OSC_IN & ~low_d);
    assign second_src_tick = wave_ctrl[`BIT_SRC_SECOND]
                           ? (HIGH_OSC_IN & ~high_d) : (LOW_OSC_IN & ~low_d);
    assign first_mask  = ratio_mask(ratio_t'(first_ctrl[3:2]));
    assign second_mask = ratio_mask(ratio_t'(second_ctrl[3:2]));
    assign first_pre_tick  = first_src_tick
                           & ((first_pre & first_mask) == first_mask);
    assign second_pre_tick = second_src_tick
                           & ((second_pre & second_mask) == second_mask);

    assign first_tick = first_run & (event_mode ? event_tick : first_pre_tick);
    assign second_tick = chain ? (first_tick && first_count == `BYTE_ZERO)
                               : (second_run & second_pre_tick);
    assign first_uf  = ~chain & first_tick & (first_count == `BYTE_ZERO);
    assign second_uf = second_tick & (second_count == `BYTE_ZERO);
    assign wave_uf   = chain ? second_uf
                     : (wave_ctrl[`BIT_CHANNEL_SEL] ? second_uf : first_uf);

    assign first_stb  = WR_IN && ADDR_IN == `OFS_FIRST_CTRL
                        && WDATA_IN[`BIT_RELOAD_STB];
    assign second_stb = WR_IN && ADDR_IN == `OFS_SECOND_CTRL
                        && WDATA_IN[`BIT_RELOAD_STB];

    always_comb begin
        next_mode_ctrl     = mode_ctrl;
        next_wave_ctrl     = wave_ctrl;
        next_first_ctrl    = first_ctrl;
        next_second_ctrl   = second_ctrl;
        next_first_reload  = first_reload;
        next_second_reload = second_reload;
        next_high_hold     = high_hold;
        next_rdata         = `BYTE_ZERO;
        next_flags         = flags;
        if (WR_IN) begin
            case (ADDR_IN)
                `OFS_MODE_CTRL:     next_mode_ctrl = WDATA_IN[3:0];
                `OFS_WAVE_CTRL:     next_wave_ctrl = WDATA_IN[3:0];
                `OFS_FIRST_CTRL:    next_first_ctrl = {WDATA_IN[3:2],
                                                       1'b0, WDATA_IN[0]};
                `OFS_SECOND_CTRL:   next_second_ctrl = {WDATA_IN[3:2],
                                                        1'b0, WDATA_IN[0]};
                `OFS_FIRST_RELOAD:  next_first_reload = WDATA_IN;
                `OFS_SECOND_RELOAD: next_second_reload = WDATA_IN;
                `OFS_FLAGS:         next_flags = flags & ~WDATA_IN[1:0];
                default:            next_flags = flags;
            endcase
        end
        // set beats a clear in the same cycle
        if (first_uf) begin
            next_flags[`BIT_FLAG_FIRST] = 1'b1;
        end
        if (second_uf) begin
            next_flags[`BIT_FLAG_SECOND] = 1'b1;
        end
        if (RD_IN) begin
            case (ADDR_IN)
                `OFS_MODE_CTRL:     next_rdata = {4'h0, mode_ctrl};
                `OFS_WAVE_CTRL:     next_rdata = {4'h0, wave_ctrl};
                `OFS_FIRST_CTRL:    next_rdata = {4'h0, first_ctrl};
                `OFS_SECOND_CTRL:   next_rdata = {4'h0, second_ctrl};
                `OFS_FIRST_RELOAD:  next_rdata = first_reload;
                `OFS_SECOND_RELOAD: next_rdata = second_reload;
                `OFS_COUNT_LOW: begin
                    next_rdata = first_count;
                    next_high_hold = second_count;
                end
                `OFS_COUNT_HIGH:    next_rdata = high_hold;
                `OFS_FLAGS:         next_rdata = {6'h00, flags};
                default:            next_rdata = `BYTE_ZERO;
            endcase
        end
    end

    always_comb begin
        next_first_pre  = first_pre;
        next_second_pre = second_pre;
        if (first_run && first_src_tick) begin
            next_first_pre = first_pre + 8'h01;
        end
        if (second_run && second_src_tick && !chain) begin
            next_second_pre = second_pre + 8'h01;
        end
        next_first_count  = first_count;
        next_second_count = second_count;
        if (first_tick) begin
            next_first_count = first_count - 8'h01;
            if (first_count == `BYTE_ZERO
                && (!chain || second_count == `BYTE_ZERO)) begin
                next_first_count = first_reload;
            end
        end
        if (second_tick) begin
            next_second_count = (second_count == `BYTE_ZERO)
                              ? second_reload : second_count - 8'h01;
        end
        if (first_stb) begin
            next_first_count = first_reload;
        end
        if (second_stb) begin
            next_second_count = second_reload;
        end
        next_wave       = wave_uf ? ~wave : wave;
        next_serial_clk = second_uf ? ~serial_clk : serial_clk;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_ctrl     <= `NIBBLE_ZERO;
            wave_ctrl     <= `NIBBLE_ZERO;
            first_ctrl    <= `NIBBLE_ZERO;
            second_ctrl   <= `NIBBLE_ZERO;
            first_reload  <= `BYTE_ZERO;
            second_reload <= `BYTE_ZERO;
            high_hold     <= `BYTE_ZERO;
            rdata         <= `BYTE_ZERO;
            flags         <= 2'h0;
        end else begin
            mode_ctrl     <= next_mode_ctrl;
            wave_ctrl     <= next_wave_ctrl;
            first_ctrl    <= next_first_ctrl;
            second_ctrl   <= next_second_ctrl;
            first_reload  <= next_first_reload;
            second_reload <= next_second_reload;
            high_hold     <= next_high_hold;
            rdata         <= next_rdata;
            flags         <= next_flags;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            first_pre    <= `BYTE_ZERO;
            second_pre   <= `BYTE_ZERO;
            first_count  <= `BYTE_ZERO;
            second_count <= `BYTE_ZERO;
            wave         <= 1'b0;
            serial_clk   <= 1'b0;
            low_d        <= 1'b0;
            high_d       <= 1'b0;
        end else begin
            first_pre    <= next_first_pre;
            second_pre   <= next_second_pre;
            first_count  <= next_first_count;
            second_count <= next_second_count;
            wave         <= next_wave;
            serial_clk   <= next_serial_clk;
            low_d        <= LOW_OSC_IN;
            high_d       <= HIGH_OSC_IN;
        end
    end

    assign RDATA_OUT       = rdata;
    // ungated enable may clip a pulse
    assign WAVE_PIN_OUT    = wave_ctrl[`BIT_WAVE_EN] ? wave : 1'b1;
    assign SERIAL_CLK_OUT  = serial_clk;
    assign SECOND_FLAG_OUT = flags[`BIT_FLAG_SECOND];
endmodule

/* bench/chain_timer_asserts.sv */
`timescale 1ns/10ps
module chain_timer_checker (
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic [3:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    input  wire logic [7:0] RDATA_OUT,
    input  wire logic       WAVE_PIN_OUT,
    input  wire logic       SERIAL_CLK_OUT,
    input  wire logic       SECOND_FLAG_OUT
);
    // shadow of {chain, chan_sel, wave_en, run_second, run_first}
    logic [4:0] ctl;
    logic [4:0] next_ctl;
    logic       active;
    logic       follow;

    always_comb begin
        next_ctl = ctl;
        if (WR_IN && ADDR_IN == 4'h0) begin
            next_ctl[4] = WDATA_IN[3];
        end
        if (WR_IN && ADDR_IN == 4'h1) begin
            next_ctl[3:2] = WDATA_IN[3:2];
        end
        if (WR_IN && ADDR_IN == 4'h2) begin
            next_ctl[0] = WDATA_IN[0];
        end
        if (WR_IN && ADDR_IN == 4'h3) begin
            next_ctl[1] = WDATA_IN[0];
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctl <= 5'h00;
        end else begin
            ctl <= next_ctl;
        end
    end

    // in chain mode only the first run bit drives the upper half
    assign active = ctl[4] ? ctl[0] : ctl[1];
    // here wave and serial clock share one underflow source
    assign follow = ctl[2] && (ctl[3] || ctl[4]);

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    sequence underflow_s;
        $changed(SERIAL_CLK_OUT);
    endsequence
    sequence clear_s;
        WR_IN && ADDR_IN == 4'h8 && WDATA_IN[1];
    endsequence

    a_wave_idle_high: assert property (
        !ctl[2] && !$past(ctl[2]) |-> WAVE_PIN_OUT)
        else $error("wave pin low while output disabled");
    a_wave_follows: assert property (
        follow [*3] |-> ($changed(WAVE_PIN_OUT) == $changed(SERIAL_CLK_OUT)))
        else $error("wave toggle does not match its underflow");
    a_serial_sets_flag: assert property (
        underflow_s |-> SECOND_FLAG_OUT)
        else $error("serial clock moved without flag");
    a_flag_needs_cause: assert property (
        $rose(SECOND_FLAG_OUT) |-> underflow_s)
        else $error("flag rose without underflow");
    a_flag_holds: assert property (
        SECOND_FLAG_OUT && !(WR_IN && ADDR_IN == 4'h8 && WDATA_IN[1])
        |=> SECOND_FLAG_OUT)
        else $error("flag dropped without clear");
    a_flag_clears: assert property (
        clear_s |=> (!SECOND_FLAG_OUT || $changed(SERIAL_CLK_OUT)))
        else $error("flag survived clear");
    a_stopped_quiet: assert property (
        !active [*3] |-> $stable(SERIAL_CLK_OUT))
        else $error("serial clock moved while stopped");
    a_strobe_reads_zero: assert property (
        RD_IN && (ADDR_IN == 4'h2 || ADDR_IN == 4'h3) |=> !RDATA_OUT[1])
        else $error("reload strobe read back as one");
endmodule

bind chain_timer chain_timer_checker u_chain_timer_checker (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .WAVE_PIN_OUT(WAVE_PIN_OUT),
    .SERIAL_CLK_OUT(SERIAL_CLK_OUT), .SECOND_FLAG_OUT(SECOND_FLAG_OUT)
);

/* bench/serial_partner.sv */
`timescale 1ns/10ps
module serial_partner (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       serial_clk_in,
    input  wire logic       wave_in,
    output logic      [7:0] edges_out,
    output logic            pin_out
);
    logic prev;
    logic port_data;
    logic port_hiz;

    assign port_data = 1'b1;
    assign port_hiz  = 1'b0;
    // the pull-up takes the pin whenever the port floats
    assign pin_out   = port_hiz | (wave_in & port_data);

    // edge counter adds one per rising serial clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev      <= 1'b0;
            edges_out <= 8'h00;
        end else begin
            prev <= serial_clk_in;
            if (serial_clk_in && !prev) begin
                edges_out <= edges_out + 8'h01;
            end
        end
    end
endmodule

/* bench/chain_timer_test.sv */
`timescale 1ns/10ps
module chain_timer_test;
    logic       SYS_CLK_IN;
    logic       RST_N_IN;
    logic [3:0] ADDR_IN;
    logic [7:0] WDATA_IN;
    logic       WR_IN;
    logic       RD_IN;
    logic [7:0] RDATA_OUT;
    logic       LOW_OSC_IN;
    logic       HIGH_OSC_IN;
    logic       FILTER_CLK_IN;
    logic       EVENT_PIN_IN;
    logic       WAVE_PIN_OUT;
    logic       SERIAL_CLK_OUT;
    logic       SECOND_FLAG_OUT;
    logic [7:0] edges;
    logic       pin;
    int         n_mismatch;
    int         n_checks;

    chain_timer u_chain_timer (
        .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
        .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
        .RDATA_OUT(RDATA_OUT), .LOW_OSC_IN(LOW_OSC_IN),
        .HIGH_OSC_IN(HIGH_OSC_IN), .FILTER_CLK_IN(FILTER_CLK_IN),
        .EVENT_PIN_IN(EVENT_PIN_IN), .WAVE_PIN_OUT(WAVE_PIN_OUT),
        .SERIAL_CLK_OUT(SERIAL_CLK_OUT), .SECOND_FLAG_OUT(SECOND_FLAG_OUT)
    );
    serial_partner u_serial_partner (
        .clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN),
        .serial_clk_in(SERIAL_CLK_OUT), .wave_in(WAVE_PIN_OUT),
        .edges_out(edges), .pin_out(pin)
    );

    initial begin
        SYS_CLK_IN = 1'b0;
        forever #5 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    // fast stand-in for the filter clock keeps the run short
    always begin
        repeat (8) @(posedge SYS_CLK_IN);
        FILTER_CLK_IN <= ~FILTER_CLK_IN;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge SYS_CLK_IN);
        ADDR_IN  <= a;
        WDATA_IN <= v;
        WR_IN    <= 1'b1;
        @(posedge SYS_CLK_IN);
        WR_IN <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK_IN);
        ADDR_IN <= a;
        RD_IN   <= 1'b1;
        @(posedge SYS_CLK_IN);
        RD_IN <= 1'b0;
        #1 check(RDATA_OUT, exp);
    endtask
    task automatic tick(input logic hi, input int n);
        repeat (n) begin
            @(posedge SYS_CLK_IN);
            LOW_OSC_IN  <= !hi;
            HIGH_OSC_IN <= hi;
            repeat (3) @(posedge SYS_CLK_IN);
            LOW_OSC_IN  <= 1'b0;
            HIGH_OSC_IN <= 1'b0;
            repeat (3) @(posedge SYS_CLK_IN);
        end
    endtask
    task automatic ev(input logic lvl, input int w);
        @(posedge SYS_CLK_IN);
        EVENT_PIN_IN <= lvl;
        repeat (w) @(posedge SYS_CLK_IN);
    endtask
    task automatic do_reset;
        @(posedge SYS_CLK_IN);
        RST_N_IN <= 1'b0;
        repeat (6) @(posedge SYS_CLK_IN);
        RST_N_IN <= 1'b1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_reset;
        do_reset;
        rdc(4'h0, 8'h00); // timer mode
        rdc(4'hF, 8'h00);
        check({7'h00, pin}, 8'h01); // pin high
        $display("reset test done");
    endtask
    task automatic t_reload;
        do_reset;
        wr(4'h4, 8'h02);
        wr(4'h2, 8'h02);
        rdc(4'h6, 8'h02); // loaded
        rdc(4'h2, 8'h00); // strobe clear
        tick(1'b0, 2);
        rdc(4'h6, 8'h02); // frozen
        wr(4'h2, 8'h01);
        tick(1'b0, 2);
        rdc(4'h6, 8'h00); // counting
        tick(1'b0, 1);
        rdc(4'h6, 8'h02); // reloaded
        rdc(4'h8, 8'h01); // flag set
        $display("reload test done");
    endtask
    task automatic t_ratio;
        int div [4] = '{1, 4, 32, 256};
        for (int r = 0; r < 4; r++) begin
            do_reset;
            // both timers share source and ratio
            wr(4'h1, {6'h00, r[0], r[0]});
            wr(4'h4, 8'hFF);
            wr(4'h5, 8'hFF);
            wr(4'h2, 8'h02);
            wr(4'h3, 8'h02);
            wr(4'h2, {4'h0, r[1:0], 2'b01});
            wr(4'h3, {4'h0, r[1:0], 2'b01});
            tick(!r[0], div[r]);
            tick(r[0], div[r] * 2);
            rdc(4'h6, 8'hFD); // two counts
            rdc(4'h7, 8'hFD); // second timer
        end
        $display("ratio test done");
    endtask
    task automatic t_wave;
        do_reset;
        wr(4'h1, 8'h0C);
        // reload of zero gives the fastest serial rate
        wr(4'h3, 8'h01);
        tick(1'b0, 7);
        check(edges, 8'h04); // serial edges
        check({7'h00, pin}, 8'h01); // halved
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h04);
        tick(1'b0, 1);
        check({7'h00, pin}, 8'h00); // first channel
        check({7'h00, SERIAL_CLK_OUT}, 8'h01); // second idle
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h01);
        tick(1'b0, 2);
        check(edges, 8'h05); // ungated
        check({7'h00, pin}, 8'h01); // held high
        $display("wave test done");
    endtask
    task automatic t_chain;
        do_reset;
        wr(4'h0, 8'h08);
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h01);
        wr(4'h2, 8'h02);
        wr(4'h3, 8'h02);
        wr(4'h2, 8'h01);
        tick(1'b0, 1);
        rdc(4'h6, 8'h00); // low byte
        tick(1'b0, 1);
        rdc(4'h7, 8'h01); // latched high
        rdc(4'h6, 8'hFF); // borrow
        rdc(4'h7, 8'h00); // high byte
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h01);
        tick(1'b0, 3);
        rdc(4'h6, 8'hFF); // held
        wr(4'h2, 8'h01);
        tick(1'b0, 256);
        rdc(4'h6, 8'h01); // reload
        check({7'h00, SECOND_FLAG_OUT}, 8'h01); // flag set
        wr(4'h8, 8'h02);
        rdc(4'h8, 8'h00); // cleared
        $display("chain test done");
    endtask
    task automatic t_event;
        do_reset;
        wr(4'h0, 8'h04);
        wr(4'h1, 8'h01);
        wr(4'h4, 8'h10);
        wr(4'h2, 8'h02);
        wr(4'h2, 8'h01);
        tick(1'b1, 2);
        tick(1'b0, 2);
        rdc(4'h6, 8'h10); // sources ignored
        ev(1'b1, 6);
        rdc(4'h6, 8'h10); // rise ignored
        ev(1'b0, 6);
        rdc(4'h6, 8'h0F); // fall counted
        wr(4'h0, 8'h05);
        ev(1'b1, 6);
        rdc(4'h6, 8'h0E); // rise counted
        ev(1'b0, 6);
        rdc(4'h6, 8'h0E); // fall ignored
        wr(4'h0, 8'h07);
        ev(1'b1, 4);
        ev(1'b0, 40);
        rdc(4'h6, 8'h0E); // glitch rejected
        ev(1'b1, 48);
        rdc(4'h6, 8'h0D); // long pulse
        $display("event test done");
    endtask

    initial begin
        repeat (40000) @(posedge SYS_CLK_IN);
        n_mismatch++;
        results;
    end

    initial begin
        RST_N_IN      = 1'b0;
        ADDR_IN       = 4'h0;
        WDATA_IN      = 8'h00;
        WR_IN         = 1'b0;
        RD_IN         = 1'b0;
        LOW_OSC_IN    = 1'b0;
        HIGH_OSC_IN   = 1'b0;
        FILTER_CLK_IN = 1'b0;
        EVENT_PIN_IN  = 1'b0;
        n_mismatch    = 0;
        n_checks      = 0;
        t_reset;
        t_reload;
        t_ratio;
        t_wave;
        t_chain;
        t_event;
        results;
    end
endmodule
